// ---- bench/vectored_interrupt_control_test.sv ----
// self-checking testbench of the vectored interrupt control block
`timescale 1ns/1ps
module vectored_interrupt_control_test;
  localparam int         TC   = 1;
  localparam logic [7:0] ENL  = vic_pkg::REG_EN_LO;
  localparam logic [7:0] ENH  = vic_pkg::REG_EN_HI;
  localparam logic [7:0] PNL  = vic_pkg::REG_PEND_LO;
  localparam logic [7:0] PNH  = vic_pkg::REG_PEND_HI;
  localparam logic [7:0] STS  = vic_pkg::REG_STATUS;
  localparam logic [4:0] TRAP = 5'h08;
  localparam logic [4:0] RET  = 5'h04;
  localparam logic [4:0] VSEL = 5'h02;

  logic               clk_i;
  logic               rst_i;
  logic [7:0]         addr_i;
  logic [7:0]         wdata_i;
  logic               wr_i;
  logic               rd_i;
  logic [7:0]         rdata_o;
  logic [12:0]        src_event_i;
  vic_pkg::vic_cpu_t  cpu_i;
  vic_pkg::vic_ack_t  ack_o;
  vic_pkg::vic_vsel_t vsel_o;
  logic [1:0]         gap;
  logic [4:0]         ctl;
  logic [12:0]        pat;
  logic               rd_prev;
  logic [15:0]        rd_q[$];
  logic [15:0]        vsel_q[$];
  logic [15:0]        ack_q[$];
  int                 err_total;
  int                 num_checks;
  int                 cyc;
  int                 push_cyc;

  vic_core #(.TC_CLKS(TC)) uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .src_event_i(src_event_i), .cpu_i(cpu_i),
    .ack_o(ack_o), .vsel_o(vsel_o));
  vic_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .ctl_i(ctl), .ack_i(ack_o), .cpu_o(cpu_i));

  always #50 clk_i = ~clk_i;

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rd_q.push_back({8'h00, e});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  task automatic setpend(input logic [12:0] p);
    wr(PNL, p[7:0]);
    wr(PNH, {3'h0, p[12:8]});
  endtask : setpend

  task automatic ev(input logic [12:0] p);
    @(posedge clk_i);
    src_event_i <= p;
    @(posedge clk_i);
    src_event_i <= 13'h0000;
  endtask : ev

  task automatic op(input logic [4:0] m);
    @(posedge clk_i);
    ctl <= ctl | m;
    @(posedge clk_i);
    ctl <= ctl & ~m;
  endtask : op

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // bounded wait until every noted acknowledge has shown up
  task automatic wait_ack(input int n);
    ack_q.push_back(vic_pkg::SERVICE_ADDR);
    for (int k = 0; k < n && ack_q.size() != 0; k++)
      @(posedge clk_i);
    if (ack_q.size() != 0)
    begin
      err_total++;
      $display("FAIL at %0t: acknowledge missing", $time);
      tally_and_finish();
    end
  endtask : wait_ack

  task automatic done(input string name);
    $display("test %s finished", name);
    gap <= 2'($urandom_range(3));
  endtask : done

  // ==========================================================================
  // result watcher: any result without a note is a mismatch
  // ==========================================================================
  always @(posedge clk_i)
  begin
    rd_prev <= rd_i;
    cyc <= cyc + 1;
  end

  always @(negedge clk_i)
  begin
    if (rd_prev)
      check({8'h00, rdata_o}, rd_q.size() != 0 ? rd_q.pop_front() : 16'hFFFF);
    if (vsel_o.valid)
      check({8'h00, vsel_o.hi_addr}, vsel_q.size() != 0 ? vsel_q.pop_front() : 16'hFFFF);
    if (ack_o.push)
      push_cyc = cyc;
    if (ack_o.pc_load)
    begin
      check(ack_o.pc, ack_q.size() != 0 ? ack_q.pop_front() : 16'hFFFF);
      check({15'h0000, ack_o.busy}, 16'h0001);
      check(16'(cyc - push_cyc), 16'(vic_pkg::ACK_TC * TC - 1));
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("FAIL at %0t: run limit reached", $time);
    tally_and_finish();
  end

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    src_event_i = 13'h0000;
    ctl = 5'h00;
    gap = 2'h0;
    rd_prev = 1'b0;
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    push_cyc = 0;
    pat = 13'($urandom(22));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++)
      rd(8'(a), 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    done("reset");
    pat = 13'($urandom);
    ev(pat);
    ev(pat);
    rd(PNL, pat[7:0]);
    rd(PNH, {3'h0, pat[12:8]});
    setpend(13'h0000);
    rd(PNH, 8'h00);
    done("pending");
    wr(ENL, 8'hFF);
    wr(ENH, 8'h1F);
    for (int i = 0; i < vic_pkg::N_MASK; i++)
    begin
      pat = (13'($urandom) | 13'h0001) << i;
      setpend(pat);
      vsel_q.push_back({8'h00, vic_pkg::VEC_TOP - 8'(2 * (i + vic_pkg::MASK_FIRST))});
      op(VSEL);
    end
    setpend(13'h0000);
    vsel_q.push_back(16'h00E0);
    op(VSEL);
    done("vector select");
    ev(13'h0020);
    @(posedge clk_i);
    ctl[0] <= 1'b1;
    op(TRAP);
    vsel_q.push_back(16'h00FE);
    op(VSEL);
    idle(20);
    rd(STS, 8'h0A);
    @(posedge clk_i);
    ctl[0] <= 1'b0;
    wait_ack(20);
    rd(STS, 8'h04);
    wr(STS, 8'h01);
    idle(20);
    rd(STS, 8'h05);
    op(RET);
    wait_ack(20);
    rd(STS, 8'h00);
    rd(PNL, 8'h20);
    wr(STS, 8'h01);
    wait_ack(20);
    wr(PNL, 8'h00);
    done("trap");
    wr(ENL, 8'h00);
    wr(ENH, 8'h00);
    ev(13'h1000);
    wr(STS, 8'h01);
    idle(20);
    wr(ENH, 8'h10);
    wait_ack(20);
    wr(PNH, 8'h00);
    done("late enable");
    @(posedge clk_i);
    ctl[4] <= 1'b1;
    wr(ENL, 8'h01);
    wr(STS, 8'h01);
    ev(13'h0001);
    idle(20);
    @(posedge clk_i);
    ctl[4] <= 1'b0;
    wait_ack(20);
    done("skip");
    // boot rom keeps the qualified request off while global enable is set, then reset mid-run
    @(posedge clk_i);
    ctl[0] <= 1'b1;
    wr(STS, 8'h01);
    rd(STS, 8'h09);
    rd(PNL, 8'h01);
    rd(ENL, 8'h01);
    @(posedge clk_i);
    rst_i <= 1'b1;
    ctl <= 5'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 5; a++)
      rd(8'(a), 8'h00);
    done("mid reset");
    tally_and_finish();
  end
endmodule : vectored_interrupt_control_test

// ---- bench/vic_cpu_model.sv ----
// instruction sequencer stand-in that drives the interrupt control block
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [1:0]        gap_i,
  input  wire logic [4:0]        ctl_i,
  input  wire vic_pkg::vic_ack_t ack_i,
  output vic_pkg::vic_cpu_t      cpu_o
);
  // ==========================================================================
  // instruction starts
  // ==========================================================================
  logic [1:0] gap_r;

  // a slow core leaves idle cycles between instructions, so events land mid-instruction
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      gap_r <= 2'h0;
    else if (ack_i.busy || gap_r == 2'h0)
      gap_r <= gap_i;
    else
      gap_r <= gap_r - 2'h1;
  end

  // no instruction starts while the acknowledge sequence owns the core
  assign cpu_o = {!ack_i.busy && gap_r == 2'h0, ctl_i};
endmodule : vic_cpu_model

// ---- logic/vic_arbiter.sv ----
// fixed priority finder: lowest index wins, last index when nothing requests
`timescale 1ns/1ps
module vic_arbiter #(
  parameter int N = 16
) (
  input  wire logic [N-1:0]         req_i,
  output logic                      found_o,
  output logic [$clog2(N)-1:0]      rank_o
);

  if (N < 2)
  begin : g_chk
    $error("vic_arbiter needs at least two ranks");
  end

  always_comb
  begin
    found_o = 1'b0;
    rank_o  = ($clog2(N))'(N - 1);
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        found_o = 1'b1;
        rank_o  = ($clog2(N))'(i);
      end
    end
  end

endmodule : vic_arbiter

// ---- logic/vic_core.sv ----
// vectored interrupt control: pending, enables, arbitration and acknowledge
//
// Operation
// - every acknowledge loads the program counter with one fixed service address.
// - software trap ranks highest, default vector-select entry ranks lowest.
// - fourteen vectored sources, thirteen maskable, each with fixed rank and vector.
// - all but the trap are maskable, each with own enable and pending.
// - a source event sets its pending flag whatever the enables say.
// - maskable pending and enable bits are software read/write registers.
// - trigger needs enable, global enable, no trap service, at instruction start.
// - maskable requests wait while the trap routine runs.
// - highest ranked qualified source served first, the others stay pending.
// - reset clears pending flags, enables and global enable.
// - enabling an already pending source triggers at once.
// - events mid-instruction are taken at the next normal instruction start.
// - a skipped instruction completes before the acknowledge.
// - acknowledge clears global enable, pushes, jumps; seven instruction cycles.
// - writing one to the status word global enable re-enables nesting.
// - return sets global enable and ends trap service.
// - requests still qualified at return are served right after it.
// - boot rom execution holds off interrupts, global enable untouched.
// - each source keeps at most one outstanding occurrence.
// - vector select finds top enabled pending source, two-byte entry, high first.
// - vector select with nothing enabled and pending uses the default entry.
`timescale 1ns/1ps
module vic_core #(
  parameter int TC_CLKS = vic_pkg::CLK_PER_TC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [7:0]                 addr_i,
  input  wire logic [7:0]                 wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [7:0]                 rdata_o,
  input  wire logic [vic_pkg::N_MASK-1:0] src_event_i,
  input  wire vic_pkg::vic_cpu_t          cpu_i,
  output vic_pkg::vic_ack_t               ack_o,
  output vic_pkg::vic_vsel_t              vsel_o
);

  localparam int ACK_CLKS = vic_pkg::ACK_TC * TC_CLKS;
  localparam int ACK_LAST = ACK_CLKS - 1;

  // the length check is one plain delay, which must stay short
  if (TC_CLKS < 1 || ACK_CLKS < 2 || ACK_CLKS > 301)
  begin : g_chk
    $error("vic_core: unusable instruction cycle length");
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [vic_pkg::N_RANK-1:0] to_ranks(
    input logic                       trap,
    input logic [vic_pkg::N_MASK-1:0] mask
  );
    logic [vic_pkg::N_RANK-1:0] r;
    r = '0;
    r[vic_pkg::RANK_TRAP] = trap;
    r[vic_pkg::MASK_FIRST +: vic_pkg::N_MASK] = mask;
    return r;
  endfunction : to_ranks

  // high byte sits at the lower address, entries descend with rank
  function automatic logic [7:0] entry_hi(input logic [vic_pkg::RANK_W-1:0] rank);
    return vic_pkg::VEC_TOP - {3'h0, rank, 1'b0};
  endfunction : entry_hi

  localparam logic [7:0] HI_DEFAULT = entry_hi(vic_pkg::RANK_DEFAULT);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ACK
  } vic_state_t;

  vic_state_t                  state_r;
  logic [15:0]                 cnt_r;
  logic [vic_pkg::N_MASK-1:0]  en_r;
  logic [vic_pkg::N_MASK-1:0]  pend_r;
  logic [vic_pkg::N_MASK-1:0]  pend_nxt;
  logic                        global_irq_enable_r;
  logic                        trap_pend_r;
  logic                        nmi_act_r;
  vic_pkg::vic_ack_t           ack_r;
  vic_pkg::vic_vsel_t          vsel_r;
  logic [7:0]                  rdata_r;

  logic [vic_pkg::N_RANK-1:0]  qual_vec;
  logic [vic_pkg::N_RANK-1:0]  sel_vec;
  logic                        qual_any;
  logic [vic_pkg::RANK_W-1:0]  take_rank;
  logic                        sel_any;
  logic [vic_pkg::RANK_W-1:0]  sel_rank;
  logic                        take;
  logic                        take_trap;
  logic                        wr_en_lo;
  logic                        wr_en_hi;
  logic                        wr_pend_lo;
  logic                        wr_pend_hi;
  logic                        wr_status;

  assign wr_en_lo   = wr_i && addr_i == vic_pkg::REG_EN_LO;
  assign wr_en_hi   = wr_i && addr_i == vic_pkg::REG_EN_HI;
  assign wr_pend_lo = wr_i && addr_i == vic_pkg::REG_PEND_LO;
  assign wr_pend_hi = wr_i && addr_i == vic_pkg::REG_PEND_HI;
  assign wr_status  = wr_i && addr_i == vic_pkg::REG_STATUS;

  // ==========================================================================
  // arbitration
  // ==========================================================================
  // trap service holds off everything, a second trap included
  assign qual_vec = to_ranks(trap_pend_r && !nmi_act_r,
                             en_r & pend_r & {vic_pkg::N_MASK{global_irq_enable_r && !nmi_act_r}});
  assign sel_vec  = to_ranks(trap_pend_r, en_r & pend_r);

  vic_arbiter #(
    .N (vic_pkg::N_RANK)
  ) u_take_arb (
    .req_i   (qual_vec),
    .found_o (qual_any),
    .rank_o  (take_rank)
  );

  vic_arbiter #(
    .N (vic_pkg::N_RANK)
  ) u_sel_arb (
    .req_i   (sel_vec),
    .found_o (sel_any),
    .rank_o  (sel_rank)
  );

  // only at the start of a normally executed instruction, never from boot rom
  assign take      = state_r == ST_IDLE && cpu_i.boundary && !cpu_i.skip
                     && !cpu_i.boot_rom && qual_any;
  assign take_trap = take && take_rank == vic_pkg::RANK_TRAP;

  // ==========================================================================
  // pending and enable registers
  // ==========================================================================
  // a single flag per source: repeats while pending merge into it
  always_comb
  begin
    pend_nxt = pend_r;
    if (wr_pend_lo)
      pend_nxt[7:0] = wdata_i;
    if (wr_pend_hi)
      pend_nxt[vic_pkg::N_MASK-1:8] = wdata_i[vic_pkg::HI_BITS-1:0];
    pend_nxt = pend_nxt | src_event_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pend_r <= '0;
    else
      pend_r <= pend_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      en_r <= '0;
    else
    begin
      if (wr_en_lo)
        en_r[7:0] <= wdata_i;
      if (wr_en_hi)
        en_r[vic_pkg::N_MASK-1:8] <= wdata_i[vic_pkg::HI_BITS-1:0];
    end
  end

  // ==========================================================================
  // global enable and trap service
  // ==========================================================================
  // acknowledge beats return and software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      global_irq_enable_r <= 1'b0;
    else if (take)
      global_irq_enable_r <= 1'b0;
    else if (cpu_i.return_from_irq)
      global_irq_enable_r <= 1'b1;
    else if (wr_status)
      global_irq_enable_r <= wdata_i[vic_pkg::STATUS_IRQ_EN];
  end

  // trap event wins over its own acknowledge clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      trap_pend_r <= 1'b0;
    else
      trap_pend_r <= (trap_pend_r && !take_trap) || cpu_i.trap;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      nmi_act_r <= 1'b0;
    else if (take_trap)
      nmi_act_r <= 1'b1;
    else if (cpu_i.return_from_irq)
      nmi_act_r <= 1'b0;
  end

  // ==========================================================================
  // acknowledge sequence
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            state_r <= ST_ACK;
            cnt_r   <= 16'(ACK_CLKS - 1);
          end
        end
        ST_ACK:
        begin
          if (cnt_r == '0)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 16'h0001;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_r.busy    <= 1'b0;
      ack_r.push    <= 1'b0;
      ack_r.pc_load <= 1'b0;
      ack_r.pc      <= vic_pkg::SERVICE_ADDR;
    end
    else
    begin
      ack_r.busy    <= take || (state_r == ST_ACK && cnt_r != '0);
      ack_r.push    <= take;
      ack_r.pc_load <= state_r == ST_ACK && cnt_r == 16'h0001;
      ack_r.pc      <= vic_pkg::SERVICE_ADDR;
    end
  end

  // ==========================================================================
  // vector select
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      vsel_r.valid   <= 1'b0;
      vsel_r.hi_addr <= HI_DEFAULT;
    end
    else
    begin
      vsel_r.valid <= cpu_i.vector_select_instruction;
      if (cpu_i.vector_select_instruction)
        vsel_r.hi_addr <= entry_hi(sel_rank);
    end
  end

  // ==========================================================================
  // register read port
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_r <= '0;
    else if (rd_i)
    begin
      case (addr_i)
        vic_pkg::REG_EN_LO:   rdata_r <= en_r[7:0];
        vic_pkg::REG_EN_HI:   rdata_r <= 8'(en_r[vic_pkg::N_MASK-1:8]);
        vic_pkg::REG_PEND_LO: rdata_r <= pend_r[7:0];
        vic_pkg::REG_PEND_HI: rdata_r <= 8'(pend_r[vic_pkg::N_MASK-1:8]);
        vic_pkg::REG_STATUS:
        begin
          rdata_r <= 8'h00;
          rdata_r[vic_pkg::STATUS_IRQ_EN] <= global_irq_enable_r;
          rdata_r[vic_pkg::STATUS_TRAP]   <= trap_pend_r;
          rdata_r[vic_pkg::STATUS_NMI]    <= nmi_act_r;
          rdata_r[vic_pkg::STATUS_BOOT]   <= cpu_i.boot_rom;
        end
        default:              rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign rdata_o = rdata_r;
  assign ack_o   = ack_r;
  assign vsel_o  = vsel_r;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_ack_run;
    ack_r.busy && ack_r.push ##ACK_LAST ack_r.busy && ack_r.pc_load;
  endsequence

  sequence s_ack_end;
    !ack_r.busy && !ack_r.pc_load;
  endsequence

  chk_ack_length: assert property (take |=> s_ack_run ##1 s_ack_end)
    else $error("acknowledge sequence has wrong length");
  chk_ack_clears_en: assert property (take |=> !global_irq_enable_r && ack_r.push)
    else $error("global enable not cleared by acknowledge");
  chk_service_addr: assert property (ack_r.pc_load |-> ack_r.pc == vic_pkg::SERVICE_ADDR && ack_r.busy)
    else $error("jump not to service address");
  chk_event_sets: assert property (|src_event_i |=> (pend_r & $past(src_event_i)) == $past(src_event_i))
    else $error("event did not set pending");
  chk_nmi_holds: assert property (nmi_act_r |-> !take)
    else $error("request taken during trap service");
  chk_boot_holds: assert property (cpu_i.boot_rom && !take |=> global_irq_enable_r == $past(global_irq_enable_r)
                                   || $past(wr_status) || $past(cpu_i.return_from_irq))
    else $error("boot rom changed global enable");
  chk_boot_no_take: assert property (cpu_i.boot_rom |-> !take)
    else $error("acknowledge during boot rom");
  chk_return_sets: assert property (cpu_i.return_from_irq && !take |=> global_irq_enable_r && !nmi_act_r)
    else $error("return did not set global enable");
  chk_top_rank: assert property (take |-> qual_vec[take_rank] && (qual_vec & ((16'h0001 << take_rank) - 16'h0001)) == '0)
    else $error("lower rank served first");
  chk_immediate: assert property (state_r == ST_IDLE && cpu_i.boundary && !cpu_i.skip && !cpu_i.boot_rom
                                  && global_irq_enable_r && !nmi_act_r
                                  && |(en_r & pend_r) |-> take)
    else $error("qualified request not taken");
  chk_skip_first: assert property (cpu_i.skip || !cpu_i.boundary |-> !take)
    else $error("acknowledge off a normal instruction start");
  chk_ack_keeps: assert property (take && !wr_pend_lo && !wr_pend_hi |=> pend_r == ($past(pend_r) | $past(src_event_i)))
    else $error("acknowledge altered pending flags");
  chk_sel_default: assert property (cpu_i.vector_select_instruction && !sel_any
                                    |=> vsel_r.valid && vsel_r.hi_addr == 8'hE0)
    else $error("default vector entry not used");

endmodule : vic_core

// ---- logic/vic_pkg.sv ----
// shared constants and carrier types of the vectored interrupt control block
package vic_pkg;

  // ==========================================================================
  // source layout
  // ==========================================================================
  localparam int N_MASK     = 13;   // maskable sources, rank order
  localparam int N_RANK     = 16;   // arbitration ranks incl. trap and default
  localparam int RANK_W     = 4;
  localparam int MASK_FIRST = 2;    // rank of maskable source 0
  localparam logic [RANK_W-1:0] RANK_TRAP    = 4'h0;
  localparam logic [RANK_W-1:0] RANK_DEFAULT = 4'hF;

  // ==========================================================================
  // register map (byte wide)
  // ==========================================================================
  localparam logic [7:0] REG_EN_LO   = 8'h00;
  localparam logic [7:0] REG_EN_HI   = 8'h01;
  localparam logic [7:0] REG_PEND_LO = 8'h02;
  localparam logic [7:0] REG_PEND_HI = 8'h03;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam int         HI_BITS       = N_MASK - 8;
  localparam int         STATUS_IRQ_EN = 0;
  localparam int         STATUS_TRAP   = 1;
  localparam int         STATUS_NMI    = 2;
  localparam int         STATUS_BOOT   = 3;

  // ==========================================================================
  // acknowledge timing
  // ==========================================================================
  localparam logic [15:0] SERVICE_ADDR = 16'h00FF;
  localparam logic [7:0]  VEC_TOP      = 8'hFE;
  localparam int          ACK_TC       = 7;      // instruction cycles
  localparam int          TC_NS        = 1000;   // one instruction cycle
  localparam int          CLK_NS       = 100;
  localparam int          CLK_PER_TC   = (TC_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic boundary;   // start of an instruction
    logic skip;       // that instruction is being skipped
    logic trap;       // software trap executed
    logic return_from_irq;            // return from interrupt executed
    logic vector_select_instruction;  // vector select executed
    logic boot_rom;   // executing from boot rom
  } vic_cpu_t;

  typedef struct packed {
    logic        busy;
    logic        push;
    logic        pc_load;
    logic [15:0] pc;
  } vic_ack_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] hi_addr;
  } vic_vsel_t;

endpackage : vic_pkg
